// [src/acs_pkg.sv]
// shared constants and types for the access-control check link
package acs_pkg;
   // ========================================================
   // packet kinds carried on the link
   typedef enum logic [2:0] {
      K_MRD   = 3'h0,
      K_MWR   = 3'h1,
      K_IORD  = 3'h2,
      K_IOWR  = 3'h3,
      K_CFGWR = 3'h4,
      K_MSG   = 3'h5,
      K_CPL   = 3'h6,
      K_CPLD  = 3'h7
   } tlp_kind_e;

   // ========================================================
   // address-type codes
   localparam logic [1:0] AT_UNTR  = 2'h0;
   localparam logic [1:0] AT_TREQ  = 2'h1;
   localparam logic [1:0] AT_TRANS = 2'h2;
   localparam logic [1:0] AT_RSVD  = 2'h3;

   // ========================================================
   // routing decision and error message codes
   typedef enum logic [1:0] {
      RT_NORMAL = 2'h0,
      RT_BLOCK  = 2'h1,
      RT_REDIR  = 2'h2
   } route_e;
   typedef enum logic [1:0] {
      MSG_NONE  = 2'h0,
      MSG_COR   = 2'h1,
      MSG_NFAT  = 2'h2,
      MSG_FATAL = 2'h3
   } msg_e;

   // ========================================================
   // completion status codes
   localparam logic [2:0] CPL_SC = 3'h0;
   localparam logic [2:0] CPL_CA = 3'h4;

   // ========================================================
   // configuration register indices (low address byte)
   localparam logic [7:0] CFG_IDX_CTRL = 8'h40;
   localparam logic [7:0] CFG_IDX_BUS  = 8'h44;
   localparam int CFG_IDX_W = 8;

   // control word fields
   localparam int CTRL_W      = 7;
   localparam int CB_SRC_VAL  = 0;
   localparam int CB_TR_BLK   = 1;
   localparam int CB_REQ_RDR  = 2;
   localparam int CB_SEV_FAT  = 3;
   localparam int CB_COR_EN   = 4;
   localparam int CB_NFAT_EN  = 5;
   localparam int CB_FAT_EN   = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
   localparam logic [2:0] CAP_ALL = 3'h7;

   // bus-number word fields
   localparam int BUS_W   = 8;
   localparam int BUS_SEC = 0;
   localparam int BUS_SUB = 8;
   localparam logic [BUS_W-1:0] BUS_RST = 8'h00;

   // ========================================================
   // widths of the header fields
   localparam int ADDR_W = 64;
   localparam int LO_W   = 32;
   localparam int DATA_W = 32;
   localparam int LOG_W  = 3 + 2 + 1 + BUS_W + 1 + ADDR_W + DATA_W;
endpackage

// [src/acs_link_if.sv]
// link carrying received packet headers from the peer into the port
`timescale 1ns/1ns
interface acs_link_if;
   logic                       valid;
   acs_pkg::tlp_kind_e         kind;
   logic [1:0]                 at;
   logic                       dw4;
   logic [acs_pkg::BUS_W-1:0]  req_bus;
   logic                       p2p;
   logic [acs_pkg::ADDR_W-1:0] addr;
   logic [acs_pkg::DATA_W-1:0] data;

   // peer side drives, checking port receives
   modport sender (output valid, kind, at, dw4, req_bus, p2p, addr, data);
   modport receiver (input valid, kind, at, dw4, req_bus, p2p, addr, data);
endinterface

// [src/acs_tlp_class.sv]
// combinational classification of one packet header
`timescale 1ns/1ns
module acs_tlp_class (
   // header fields
   input  wire acs_pkg::tlp_kind_e i_kind,
   input  wire logic [1:0]         i_at,
   // classes
   output logic                    o_mem_rw,
   output logic                    o_addr_rt,
   output logic                    o_req,
   output logic                    o_np,
   output logic                    o_cpl,
   output logic                    o_at_nondef
);
   // ========================================================
   // kind decode
   always_comb begin
      o_mem_rw  = (i_kind == acs_pkg::K_MRD) || (i_kind == acs_pkg::K_MWR);
      o_addr_rt = o_mem_rw || (i_kind == acs_pkg::K_IORD) ||
                  (i_kind == acs_pkg::K_IOWR);
      o_cpl     = (i_kind == acs_pkg::K_CPL) || (i_kind == acs_pkg::K_CPLD);
      o_req     = !o_cpl;
      o_np      = o_req && (i_kind != acs_pkg::K_MWR) && (i_kind != acs_pkg::K_MSG);
      // address type counts only on memory read and write
      o_at_nondef = o_mem_rw && (i_at != acs_pkg::AT_UNTR);
   end
endmodule

// [src/acs_port_check.sv]
// receiving port: access-control check, routing decision, error signaling
`timescale 1ns/1ns
// Operation
// - enabled checks classify each packet: normal, block, redirect
// - nothing configured means plain routing, no checks
// - memory address type 00 untranslated, 01 request, 10 translated
// - code 11 and non-memory address type are reserved
// - address in 4DW header 64-bit, 3DW 32-bit
// - memory and IO requests are address routed
// - violation only for requests breaching an enabled check
// - violation sends non-fatal message and logs header
// - non-posted violation also returns Completer Abort completion
// - non-fatal non-posted violation is advisory
// - advisory: correctable message if error reporting and enabled
// - fatal severity sends fatal message if enabled
// - unexpected completion sends non-fatal message, logs header
// - receive overflow sends fatal message
// - bad read data may be poisoned instead
// - report implemented subset through capability bits
// - software programs control through configuration writes
// - redirect needs upstream forwarding along the path
// - source check: requester bus within secondary..subordinate
// - translation blocking flags non-default memory address type
// - all checks disabled after reset
// - completions skip source and translation checks
module acs_port_check #(
   parameter logic [2:0] CAP     = acs_pkg::CAP_ALL, // valid, block, redirect
   parameter bit         HAS_AER = 1'b1,
   parameter bit         PATH_UF = 1'b1              // upstream forwarding on path
) (
   // clock and reset
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_resetn,
   // link from the peer
   acs_link_if.receiver                    lnk,
   // routing logic hints
   input  wire logic                       i_cpl_match,
   input  wire logic                       i_rx_overflow,
   input  wire logic                       i_rsp_valid,
   input  wire logic                       i_rsp_bad,
   // forwarded packets
   output logic                            o_fwd_valid,
   output logic                            o_fwd_redir,
   output acs_pkg::tlp_kind_e              o_fwd_kind,
   output logic [acs_pkg::ADDR_W-1:0]      o_fwd_addr,
   output logic [acs_pkg::DATA_W-1:0]      o_fwd_data,
   output acs_pkg::route_e                 o_route,
   // error path toward the root complex
   output logic                            o_msg_valid,
   output acs_pkg::msg_e                   o_msg_code,
   output logic                            o_log_valid,
   output logic [acs_pkg::LOG_W-1:0]       o_log_hdr,
   // completions returned by this completer
   output logic                            o_cpl_valid,
   output logic [2:0]                      o_cpl_status,
   output logic                            o_cpl_poison,
   // configuration and capability view
   output logic [acs_pkg::CTRL_W-1:0]      o_ctrl,
   output logic [acs_pkg::BUS_W-1:0]       o_sec_bus,
   output logic [acs_pkg::BUS_W-1:0]       o_sub_bus,
   output logic [2:0]                      o_cap
);
   // ========================================================
   // header classification
   logic mem_rw;
   logic addr_rt;
   logic is_req;
   logic is_np;
   logic is_cpl;
   logic at_nondef;

   acs_tlp_class u_class (
      .i_kind      (lnk.kind),
      .i_at        (lnk.at),
      .o_mem_rw    (mem_rw),
      .o_addr_rt   (addr_rt),
      .o_req       (is_req),
      .o_np        (is_np),
      .o_cpl       (is_cpl),
      .o_at_nondef (at_nondef)
   );

   // ========================================================
   // state
   logic                       fwd_v_reg, fwd_v_next;
   logic                       fwd_r_reg, fwd_r_next;
   acs_pkg::tlp_kind_e         fwd_k_reg, fwd_k_next;
   logic [acs_pkg::ADDR_W-1:0] fwd_a_reg, fwd_a_next;
   logic [acs_pkg::DATA_W-1:0] fwd_d_reg, fwd_d_next;
   acs_pkg::route_e            rt_reg, rt_next;
   logic                       msg_v_reg, msg_v_next;
   acs_pkg::msg_e              msg_c_reg, msg_c_next;
   logic                       log_v_reg, log_v_next;
   logic [acs_pkg::LOG_W-1:0]  log_h_reg, log_h_next;
   logic                       cpl_v_reg, cpl_v_next;
   logic [2:0]                 cpl_s_reg, cpl_s_next;
   logic                       cpl_p_reg, cpl_p_next;
   logic [acs_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic [acs_pkg::BUS_W-1:0]  sec_reg, sec_next;
   logic [acs_pkg::BUS_W-1:0]  sub_reg, sub_next;
   logic [2:0]                 cap_reg;

   // working terms
   logic                       en_sv;
   logic                       en_tb;
   logic                       en_rr;
   logic                       sv_fail;
   logic                       tb_fail;
   logic                       viol;
   logic                       unexp;
   logic                       cfg_hit;
   logic [acs_pkg::ADDR_W-1:0] rt_addr;
   acs_pkg::msg_e              viol_msg;

   // ========================================================
   // checks; enables are masked by what is built
   always_comb begin
      en_sv = ctrl_reg[acs_pkg::CB_SRC_VAL] && CAP[0];
      en_tb = ctrl_reg[acs_pkg::CB_TR_BLK] && CAP[1];
      // redirect is useless unless the path forwards upstream
      en_rr = ctrl_reg[acs_pkg::CB_REQ_RDR] && CAP[2] && PATH_UF;
      // requests only: completions never take these
      sv_fail = en_sv && is_req &&
                ((lnk.req_bus < sec_reg) || (lnk.req_bus > sub_reg));
      tb_fail = en_tb && at_nondef;
      viol    = lnk.valid && (sv_fail || tb_fail);
      unexp   = lnk.valid && is_cpl && !i_cpl_match;
      cfg_hit = lnk.valid && !viol && (lnk.kind == acs_pkg::K_CFGWR) &&
                ((lnk.addr[acs_pkg::CFG_IDX_W-1:0] == acs_pkg::CFG_IDX_CTRL) ||
                 (lnk.addr[acs_pkg::CFG_IDX_W-1:0] == acs_pkg::CFG_IDX_BUS));
      // a 3DW header carries only the low address word
      rt_addr = lnk.dw4 ? lnk.addr :
                {{(acs_pkg::ADDR_W-acs_pkg::LO_W){1'b0}}, lnk.addr[acs_pkg::LO_W-1:0]};
      // severity of a violation message
      if (ctrl_reg[acs_pkg::CB_SEV_FAT]) begin
         viol_msg = ctrl_reg[acs_pkg::CB_FAT_EN] ? acs_pkg::MSG_FATAL
                                                  : acs_pkg::MSG_NONE;
      end else if (is_np) begin
         // advisory case; no reporting block means no message
         viol_msg = (HAS_AER && ctrl_reg[acs_pkg::CB_COR_EN]) ? acs_pkg::MSG_COR
                                                               : acs_pkg::MSG_NONE;
      end else begin
         viol_msg = acs_pkg::MSG_NFAT;
      end
   end

   // ========================================================
   // next values of all output state but the capability bits
   always_comb begin
      fwd_v_next = 1'b0;
      fwd_r_next = 1'b0;
      fwd_k_next = fwd_k_reg;
      fwd_a_next = fwd_a_reg;
      fwd_d_next = fwd_d_reg;
      rt_next    = rt_reg;
      msg_v_next = 1'b0;
      msg_c_next = msg_c_reg;
      log_v_next = 1'b0;
      log_h_next = log_h_reg;
      cpl_v_next = 1'b0;
      cpl_s_next = cpl_s_reg;
      cpl_p_next = 1'b0;
      ctrl_next  = ctrl_reg;
      sec_next   = sec_reg;
      sub_next   = sub_reg;

      // control is reached by ordinary configuration writes
      if (cfg_hit) begin
         if (lnk.addr[acs_pkg::CFG_IDX_W-1:0] == acs_pkg::CFG_IDX_CTRL) begin
            ctrl_next = lnk.data[acs_pkg::CTRL_W-1:0];
         end else begin
            sec_next = lnk.data[acs_pkg::BUS_SEC +: acs_pkg::BUS_W];
            sub_next = lnk.data[acs_pkg::BUS_SUB +: acs_pkg::BUS_W];
         end
      end

      // classify every packet except a consumed config write; with no enables set all route normally
      if (lnk.valid && !cfg_hit) begin
         fwd_k_next = lnk.kind;
         fwd_a_next = addr_rt ? rt_addr : lnk.addr;
         fwd_d_next = lnk.data;
         if (viol) begin
            rt_next = acs_pkg::RT_BLOCK;
         end else if (en_rr && lnk.p2p && is_req) begin
            rt_next    = acs_pkg::RT_REDIR;
            fwd_v_next = !unexp;
            fwd_r_next = 1'b1;
         end else begin
            rt_next    = acs_pkg::RT_NORMAL;
            fwd_v_next = !unexp; // stray completions go nowhere
         end
      end

      // header log of the offending packet
      if (viol || unexp) begin
         log_v_next = 1'b1;
         log_h_next = {lnk.kind, lnk.at, lnk.dw4, lnk.req_bus, lnk.p2p,
                       lnk.addr, lnk.data};
      end

      // message choice; overflow outranks a packet error in the same cycle
      if (i_rx_overflow) begin
         msg_v_next = 1'b1;
         msg_c_next = acs_pkg::MSG_FATAL;
      end else if (viol && (viol_msg != acs_pkg::MSG_NONE)) begin
         msg_v_next = 1'b1;
         msg_c_next = viol_msg;
      end else if (unexp) begin
         msg_v_next = 1'b1;
         msg_c_next = acs_pkg::MSG_NFAT;
      end

      // abort completion for a blocked non-posted request
      if (viol && is_np) begin
         cpl_v_next = 1'b1;
         cpl_s_next = acs_pkg::CPL_CA;
      end else if (i_rsp_valid) begin
         // bad data goes back poisoned with normal status
         cpl_v_next = 1'b1;
         cpl_s_next = acs_pkg::CPL_SC;
         cpl_p_next = i_rsp_bad;
      end
   end

   // ========================================================
   // registers; every check starts disabled
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         fwd_v_reg <= 1'b0;
         fwd_r_reg <= 1'b0;
         fwd_k_reg <= acs_pkg::K_MRD;
         fwd_a_reg <= '0;
         fwd_d_reg <= '0;
         rt_reg    <= acs_pkg::RT_NORMAL;
         msg_v_reg <= 1'b0;
         msg_c_reg <= acs_pkg::MSG_NONE;
         log_v_reg <= 1'b0;
         log_h_reg <= '0;
         cpl_v_reg <= 1'b0;
         cpl_s_reg <= acs_pkg::CPL_SC;
         cpl_p_reg <= 1'b0;
         ctrl_reg  <= acs_pkg::CTRL_RST;
         sec_reg   <= acs_pkg::BUS_RST;
         sub_reg   <= acs_pkg::BUS_RST;
         cap_reg   <= CAP;
      end else begin
         fwd_v_reg <= fwd_v_next;
         fwd_r_reg <= fwd_r_next;
         fwd_k_reg <= fwd_k_next;
         fwd_a_reg <= fwd_a_next;
         fwd_d_reg <= fwd_d_next;
         rt_reg    <= rt_next;
         msg_v_reg <= msg_v_next;
         msg_c_reg <= msg_c_next;
         log_v_reg <= log_v_next;
         log_h_reg <= log_h_next;
         cpl_v_reg <= cpl_v_next;
         cpl_s_reg <= cpl_s_next;
         cpl_p_reg <= cpl_p_next;
         ctrl_reg  <= ctrl_next;
         sec_reg   <= sec_next;
         sub_reg   <= sub_next;
         cap_reg   <= CAP;
      end
   end

   // ========================================================
   // outputs straight from flops
   assign o_fwd_valid  = fwd_v_reg;
   assign o_fwd_redir  = fwd_r_reg;
   assign o_fwd_kind   = fwd_k_reg;
   assign o_fwd_addr   = fwd_a_reg;
   assign o_fwd_data   = fwd_d_reg;
   assign o_route      = rt_reg;
   assign o_msg_valid  = msg_v_reg;
   assign o_msg_code   = msg_c_reg;
   assign o_log_valid  = log_v_reg;
   assign o_log_hdr    = log_h_reg;
   assign o_cpl_valid  = cpl_v_reg;
   assign o_cpl_status = cpl_s_reg;
   assign o_cpl_poison = cpl_p_reg;
   assign o_ctrl       = ctrl_reg;
   assign o_sec_bus    = sec_reg;
   assign o_sub_bus    = sub_reg;
   assign o_cap        = cap_reg;
endmodule

// [src/acs_link_sender.sv]
// peer end: forms well-formed packet headers onto the link
`timescale 1ns/1ns
module acs_link_sender #(
   parameter bit PATH_UF = 1'b1 // upstream forwarding on the path
) (
   // clock and reset
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_resetn,
   // request from the user
   input  wire logic                       i_send,
   input  wire acs_pkg::tlp_kind_e         i_kind,
   input  wire logic [1:0]                 i_at,
   input  wire logic [acs_pkg::BUS_W-1:0]  i_req_bus,
   input  wire logic                       i_p2p,
   input  wire logic [acs_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [acs_pkg::DATA_W-1:0] i_data,
   // link toward the checking port
   acs_link_if.sender                      lnk
);
   // ========================================================
   // header state
   logic                       v_reg, v_next;
   acs_pkg::tlp_kind_e         k_reg, k_next;
   logic [1:0]                 at_reg, at_next;
   logic                       dw4_reg, dw4_next;
   logic [acs_pkg::BUS_W-1:0]  bus_reg, bus_next;
   logic                       p2p_reg, p2p_next;
   logic [acs_pkg::ADDR_W-1:0] a_reg, a_next;
   logic [acs_pkg::DATA_W-1:0] d_reg, d_next;
   logic                       mem_rw;
   logic                       addr_rt;

   // ========================================================
   // build the header; one packet per send pulse
   always_comb begin
      mem_rw  = (i_kind == acs_pkg::K_MRD) || (i_kind == acs_pkg::K_MWR);
      addr_rt = mem_rw || (i_kind == acs_pkg::K_IORD) || (i_kind == acs_pkg::K_IOWR);
      v_next   = i_send;
      k_next   = i_send ? i_kind : k_reg;
      bus_next = i_send ? i_req_bus : bus_reg;
      a_next   = i_send ? i_addr : a_reg;
      d_next   = i_send ? i_data : d_reg;
      // reserved codes go out as zero
      at_next  = (i_send && mem_rw && (i_at != acs_pkg::AT_RSVD)) ? i_at : acs_pkg::AT_UNTR;
      // 4DW header only when the high word is needed
      dw4_next = i_send && addr_rt && (|i_addr[acs_pkg::ADDR_W-1:acs_pkg::LO_W]);
      // peer traffic marked only where the path can forward it back
      p2p_next = i_send && i_p2p && PATH_UF;
   end

   // header registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         v_reg   <= 1'b0;
         k_reg   <= acs_pkg::K_MRD;
         at_reg  <= acs_pkg::AT_UNTR;
         dw4_reg <= 1'b0;
         bus_reg <= '0;
         p2p_reg <= 1'b0;
         a_reg   <= '0;
         d_reg   <= '0;
      end else begin
         v_reg   <= v_next;
         k_reg   <= k_next;
         at_reg  <= at_next;
         dw4_reg <= dw4_next;
         bus_reg <= bus_next;
         p2p_reg <= p2p_next;
         a_reg   <= a_next;
         d_reg   <= d_next;
      end
   end

   // link pins from flops
   assign lnk.valid   = v_reg;
   assign lnk.kind    = k_reg;
   assign lnk.at      = at_reg;
   assign lnk.dw4     = dw4_reg;
   assign lnk.req_bus = bus_reg;
   assign lnk.p2p     = p2p_reg;
   assign lnk.addr    = a_reg;
   assign lnk.data    = d_reg;
endmodule

// [test/acs_link_props.sv]
// checker for the header fields carried on the link between the two ends
`timescale 1ns/1ns
module acs_link_props (
   // clock and reset
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_resetn,
   // link signals
   input  wire logic                       valid,
   input  wire acs_pkg::tlp_kind_e         kind,
   input  wire logic [1:0]                 at,
   input  wire logic                       dw4,
   input  wire logic [acs_pkg::BUS_W-1:0]  req_bus,
   input  wire logic                       p2p,
   input  wire logic [acs_pkg::ADDR_W-1:0] addr,
   input  wire logic [acs_pkg::DATA_W-1:0] data
);
   // ================
   // own kind decode, independent of the design
   logic mem_rw;
   logic addr_rt;
   logic is_cpl;
   logic hi_set;
   assign mem_rw  = (kind == acs_pkg::K_MRD) || (kind == acs_pkg::K_MWR);
   assign addr_rt = mem_rw || (kind == acs_pkg::K_IORD) || (kind == acs_pkg::K_IOWR);
   assign is_cpl  = (kind == acs_pkg::K_CPL) || (kind == acs_pkg::K_CPLD);
   assign hi_set  = |addr[63:32];

   // ================
   // one domain: clocking and reset given once
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   a_at_rsvd_code: assert property (valid |-> at != acs_pkg::AT_RSVD)
      else $error("reserved address type");
   a_at_nonmem_zero: assert property (valid && !mem_rw |-> at == acs_pkg::AT_UNTR)
      else $error("address type on non-memory");
   a_cpl_plain_hdr: assert property (valid && is_cpl |-> at == 2'h0 && !dw4)
      else $error("completion header not plain");
   a_nonrt_short_hdr: assert property (valid && !addr_rt |-> !dw4)
      else $error("long header, not address routed");
   a_long_hdr_high: assert property (valid && dw4 |-> hi_set)
      else $error("long header, short address");
   a_high_long_hdr: assert property (valid && addr_rt && hi_set |-> dw4)
      else $error("long address, short header");
   a_reset_quiet: assert property ($rose(i_resetn) |-> !valid)
      else $error("packet right after reset");
   // kind, address, data and requester bus hold between beats; the receiver logs them
   a_fields_hold: assert property (!valid |-> $stable(kind) && $stable(addr)
                                   && $stable(data) && $stable(req_bus))
      else $error("fields moved while idle");
endmodule

// [test/acs_tlp_access_check_tb.sv]
// testbench joining sender and checking port across the link
`timescale 1ns/1ns
module acs_tlp_access_check_tb;
   // ================
   // stimulus and counters
   logic               i_sys_clk = 1'b0;
   logic               i_resetn  = 1'b0;
   logic               send      = 1'b0;
   acs_pkg::tlp_kind_e kind;
   logic [1:0]         at;
   logic [7:0]         bus;
   logic               p2p;
   logic [63:0]        addr;
   logic [31:0]        data;
   logic               cpl_match = 1'b1;
   logic               ovf       = 1'b0;
   logic               rsp_v     = 1'b0;
   logic               rsp_bad   = 1'b0;
   int                 errors    = 0;
   int                 n_tests   = 0;
   // observed outputs
   logic                      fwd_v, fwd_r, msg_v, log_v, cpl_v, cpl_p;
   acs_pkg::tlp_kind_e        fwd_kind;
   logic [63:0]               fwd_addr;
   logic [31:0]               fwd_data;
   acs_pkg::route_e           route;
   acs_pkg::msg_e             msg_c;
   logic [acs_pkg::LOG_W-1:0] log_h;
   logic [2:0]                cpl_s, cap;
   logic [6:0]                ctrl;
   logic [7:0]                sec, sub;

   always #25 i_sys_clk = ~i_sys_clk;

   // ================
   // the two ends, the link and its checker
   acs_link_if lnk ();
   acs_link_sender i_acs_link_sender (.i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn), .i_send(send), .i_kind(kind), .i_at(at), .i_req_bus(bus),
      .i_p2p(p2p), .i_addr(addr), .i_data(data), .lnk(lnk.sender));
   acs_port_check i_acs_port_check (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .lnk(lnk.receiver), .i_cpl_match(cpl_match),
      .i_rx_overflow(ovf), .i_rsp_valid(rsp_v), .i_rsp_bad(rsp_bad), .o_fwd_valid(fwd_v),
      .o_fwd_redir(fwd_r), .o_fwd_kind(fwd_kind), .o_fwd_addr(fwd_addr), .o_fwd_data(fwd_data),
      .o_route(route), .o_msg_valid(msg_v), .o_msg_code(msg_c), .o_log_valid(log_v),
      .o_log_hdr(log_h), .o_cpl_valid(cpl_v), .o_cpl_status(cpl_s), .o_cpl_poison(cpl_p),
      .o_ctrl(ctrl), .o_sec_bus(sec), .o_sub_bus(sub), .o_cap(cap));
   acs_link_props i_acs_link_props (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
      .valid(lnk.valid), .kind(lnk.kind), .at(lnk.at), .dw4(lnk.dw4), .req_bus(lnk.req_bus),
      .p2p(lnk.p2p), .addr(lnk.addr), .data(lnk.data));

   // ================
   // shared tasks
   task automatic chk(input logic [acs_pkg::LOG_W-1:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one packet; outputs are judged one cycle after it crosses
   task automatic xfer(input acs_pkg::tlp_kind_e k, logic [1:0] a, logic [7:0] b, logic p,
                       logic [63:0] ad, logic [31:0] d);
      send = 1'b1;
      kind = k;
      at   = a;
      bus  = b;
      p2p  = p;
      addr = ad;
      data = d;
      @(negedge i_sys_clk);
      send = 1'b0;
      @(negedge i_sys_clk);
   endtask
   task automatic look(input logic fv, acs_pkg::route_e rt, logic lv, mv, acs_pkg::msg_e mc,
                       logic cv);
      chk(fwd_v, fv);
      chk(route, rt);
      chk(log_v, lv);
      chk(msg_v, mv);
      chk(cpl_v, cv);
      if (mv) chk(msg_c, mc);
      if (cv) chk(cpl_s, acs_pkg::CPL_CA);
   endtask
   task automatic ok_norm;
      look(1'b1, acs_pkg::RT_NORMAL, 1'b0, 1'b0, acs_pkg::MSG_NONE, 1'b0);
   endtask
   task automatic blk(input logic mv, acs_pkg::msg_e mc, logic cv);
      look(1'b0, acs_pkg::RT_BLOCK, 1'b1, mv, mc, cv);
   endtask
   // consumed config write; bus 10 stays inside the source aperture
   task automatic cfg(input logic [7:0] idx, input logic [31:0] d);
      xfer(acs_pkg::K_CFGWR, 2'h0, 8'h10, 1'b0, {56'h0, idx}, d);
      chk(fwd_v, 1'b0);
      @(negedge i_sys_clk);
   endtask

   // ================
   // scenarios
   task automatic t_reset;
      chk(ctrl, acs_pkg::CTRL_RST);
      chk({sec, sub}, 16'h0000);
      chk(cap, acs_pkg::CAP_ALL);
      $display("test reset done");
   endtask
   task automatic t_plain;
      xfer(acs_pkg::K_MRD, 2'h1, 8'h55, 1'b0, 64'h1_0000_0040, 32'h0);
      ok_norm();
      chk(fwd_addr, 64'h1_0000_0040);
      xfer(acs_pkg::K_IOWR, 2'h0, 8'h55, 1'b0, 64'h80, 32'h1234_5678);
      chk({fwd_v, fwd_kind}, {1'b1, acs_pkg::K_IOWR});
      chk({fwd_addr, fwd_data}, {64'h80, 32'h1234_5678});
      xfer(acs_pkg::K_MWR, 2'h3, 8'h55, 1'b0, 64'h40, 32'h1);
      ok_norm();
      $display("test plain done");
   endtask
   task automatic t_cfg;
      cfg(acs_pkg::CFG_IDX_BUS, 32'h0000_2010);
      chk({sec, sub}, 16'h1020);
      cfg(acs_pkg::CFG_IDX_CTRL, 32'h13);
      chk(ctrl, 7'h13);
      $display("test config done");
   endtask
   task automatic t_src;
      xfer(acs_pkg::K_MRD, 2'h0, 8'h30, 1'b0, 64'h1000, 32'h0);
      blk(1'b1, acs_pkg::MSG_COR, 1'b1);
      chk(log_h, {acs_pkg::K_MRD, 2'h0, 1'b0, 8'h30, 1'b0, 64'h1000, 32'h0});
      xfer(acs_pkg::K_MWR, 2'h0, 8'h0f, 1'b0, 64'h2000, 32'h5);
      blk(1'b1, acs_pkg::MSG_NFAT, 1'b0);
      xfer(acs_pkg::K_MRD, 2'h0, 8'h10, 1'b0, 64'h1000, 32'h0);
      ok_norm();
      xfer(acs_pkg::K_MWR, 2'h0, 8'h20, 1'b0, 64'h1000, 32'h0);
      ok_norm();
      $display("test source done");
   endtask
   task automatic t_trans;
      xfer(acs_pkg::K_MWR, 2'h2, 8'h15, 1'b0, 64'h3000, 32'h7);
      blk(1'b1, acs_pkg::MSG_NFAT, 1'b0);
      xfer(acs_pkg::K_MRD, 2'h1, 8'h15, 1'b0, 64'h3000, 32'h0);
      blk(1'b1, acs_pkg::MSG_COR, 1'b1);
      xfer(acs_pkg::K_CPLD, 2'h0, 8'h99, 1'b0, 64'h0, 32'h9);
      ok_norm();
      // io keeps no address type, so blocking cannot trip
      xfer(acs_pkg::K_IORD, 2'h2, 8'h15, 1'b0, 64'h60, 32'h0);
      ok_norm();
      $display("test translation done");
   endtask
   task automatic t_sev;
      cfg(acs_pkg::CFG_IDX_CTRL, 32'h4b);
      xfer(acs_pkg::K_MRD, 2'h0, 8'h30, 1'b0, 64'h1000, 32'h0);
      blk(1'b1, acs_pkg::MSG_FATAL, 1'b1);
      cfg(acs_pkg::CFG_IDX_CTRL, 32'h0b);
      xfer(acs_pkg::K_MWR, 2'h0, 8'h30, 1'b0, 64'h1000, 32'h0);
      blk(1'b0, acs_pkg::MSG_NONE, 1'b0);
      cfg(acs_pkg::CFG_IDX_CTRL, 32'h03);
      xfer(acs_pkg::K_MRD, 2'h0, 8'h30, 1'b0, 64'h1000, 32'h0);
      blk(1'b0, acs_pkg::MSG_NONE, 1'b1);
      $display("test severity done");
   endtask
   task automatic t_redir;
      cfg(acs_pkg::CFG_IDX_CTRL, 32'h04);
      xfer(acs_pkg::K_MWR, 2'h0, 8'h77, 1'b1, 64'h4000, 32'h2);
      look(1'b1, acs_pkg::RT_REDIR, 1'b0, 1'b0, acs_pkg::MSG_NONE, 1'b0);
      chk(fwd_r, 1'b1);
      xfer(acs_pkg::K_MWR, 2'h0, 8'h77, 1'b0, 64'h4000, 32'h2);
      ok_norm();
      chk(fwd_r, 1'b0);
      $display("test redirect done");
   endtask
   task automatic t_events;
      cpl_match = 1'b0;
      xfer(acs_pkg::K_CPL, 2'h0, 8'h44, 1'b0, 64'h0, 32'h0);
      cpl_match = 1'b1;
      chk({fwd_v, log_v, msg_v, msg_c}, {3'b011, acs_pkg::MSG_NFAT});
      ovf = 1'b1;
      @(negedge i_sys_clk);
      ovf = 1'b0;
      chk({msg_v, msg_c}, {1'b1, acs_pkg::MSG_FATAL});
      rsp_v   = 1'b1;
      rsp_bad = 1'b1;
      @(negedge i_sys_clk);
      rsp_v = 1'b0;
      chk({cpl_v, cpl_s, cpl_p}, {1'b1, acs_pkg::CPL_SC, 1'b1});
      $display("test events done");
   endtask

   // ================
   // verdict, reached from the main sequence or the watchdog
   task automatic close_out;
      $display("compares %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(negedge i_sys_clk);
      i_resetn = 1'b1;
      t_reset();
      t_plain();
      t_cfg();
      t_src();
      t_trans();
      t_sev();
      t_redir();
      t_events();
      close_out();
   end
   // tests need under 200 cycles; this cuts a hang short
   initial begin
      #(50 * 4000);
      errors++;
      close_out();
   end
endmodule
